// ===== rtl/nia_arbiter.sv
// Nested interrupt arbiter: external channels, top level, peripheral channel, return
// Functional notes
// - Return restores flags, segment, PC, enable, level
// - Without segment save, return switches segment back
// - Eight external channels in four pairs
// - Edge select picks rising/falling; mask gates
// - Pair field gives even level, odd next
// - Channels 1-6 source is pin or peripheral; channel 0 pin or watchdog, channel 7 top pin or wakeup line
// - Top source: pin when select high, else watchdog
// - Top pin edge chosen by edge select
// - Selected top event sets top pending
// - Maskable top path needs global enable
// - Unmaskable lock settable, cleared only by reset
// - Top routine blocks every other request
// - Top handling leaves enable and levels alone
// - Peripheral pending set by hardware or software
// - Peripheral request needs mask, pending, enable
// - Peripheral three-bit level; seven never acknowledged
// - Peripheral vector field up to seven bits
// - Arbitration every five cycles, ack adds one
// - Abort instruction unless it already wrote
// - Response window set by entry and arbitration
// - Entry eighteen clocks plus stack, segment, wait
// - Ack records level in hold bit, loads new
// - Hold bit cleared on return resuming routine
// - External pending cleared on acknowledge
// - Equal levels resolved by fixed chain order
`timescale 1ns/1ps
module nia_arbiter #(
	parameter int NCH = 8
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	// Register port
	input  wire nia_pkg::nia_bus_t bus_i,
	output logic [7:0]             rdata_o,
	// Sources
	input  wire logic [NCH-1:0]    ext_pin_i,
	input  wire logic [NCH-1:0]    periph_irq_i,
	input  wire logic              nmi_pin_i,
	input  wire logic              wdog_eoc_i,
	input  wire logic              wakeup_line_i,
	input  wire logic              periph_event_i,
	// Core sequencer
	input  wire logic              iret_i,
	input  wire logic              insn_wrote_i,
	input  wire logic              stack_in_rf_i,
	input  wire logic              wfi_i,
	output nia_pkg::nia_req_t      req_o,
	output logic                   entry_busy_o,
	output logic                   use_isr_o,
	output logic [3:0]             pop_step_o,
	output logic [2:0]             cpl_o
);
	typedef struct packed {
		logic [7:0]         central_irq_control;
		logic [7:0]         edge_sel;
		logic [7:0]         pend;
		logic [7:0]         mask;
		logic [7:0]         prio;
		logic [7:0]         vect;
		logic [7:0]         hold;
		logic [7:0]         pctl;
		logic [6:0]         pvec;
		logic [7:0]         srcsel;
		logic [1:0][NCH-1:0] s_ext;
		logic [1:0]         s_nmi;
		logic [NCH-1:0]     last_ext;
		logic               last_nmi;
		logic               last_wdog;
		logic [2:0]         arb_cnt;
		nia_pkg::nia_phase_t phase;
		logic [4:0]         entry_cnt;
		logic               in_top;
		logic               seg_saved;
		logic [3:0]         nest;
		logic [3:0]         pop_step;
		logic [7:0]         rdata;
		logic               busy;
		logic               use_isr;
		nia_pkg::nia_req_t  req;
	} nia_state_t;

	nia_state_t q;
	nia_state_t n;

	logic [NCH-1:0] src;
	logic [NCH-1:0] ext_edge;
	logic [2:0]     lvl [NCH];
	logic           top_src;
	logic           top_edge;
	logic           top_req;
	logic           win_ok;
	logic [3:0]     win_idx;
	logic [2:0]     win_lvl;
	logic [2:0]     next_lvl;
	logic [3:0]     hl_idx;
	logic [4:0]     entry_len;

	// Per-channel source mux, edge and level
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			if (g == NCH - 1) begin : g_d1
				assign src[g] = q.srcsel[g] ? q.s_nmi[1] : wakeup_line_i;
			end else if (g == 0) begin : g_a0
				assign src[g] = q.vect[nia_pkg::BIT_CHAN_A0_SOURCE_SELECT] ? q.s_ext[1][g] : wdog_eoc_i;
			end else begin : g_mid
				assign src[g] = q.srcsel[g] ? q.s_ext[1][g] : periph_irq_i[g];
			end
			assign ext_edge[g] = q.edge_sel[g] ? (src[g] & ~q.last_ext[g])
							   : (~src[g] & q.last_ext[g]);
			assign lvl[g] = {q.prio[2*(g/2)+1], q.prio[2*(g/2)], 1'(g % 2)};
		end
	endgenerate

	// Top-level source, edge and gating
	always_comb begin
		top_src  = q.vect[nia_pkg::BIT_TOP_SOURCE_SELECT] ? q.s_nmi[1] : wdog_eoc_i;
		if (q.vect[nia_pkg::BIT_TOP_SOURCE_SELECT]) begin
			top_edge = q.vect[nia_pkg::BIT_TOP_EDGE_SELECT] ? (top_src & ~q.last_nmi)
							       : (~top_src & q.last_nmi);
		end else begin
			top_edge = top_src & ~q.last_wdog;
		end
		top_req = q.central_irq_control[nia_pkg::BIT_TOP_PENDING] &
			  (q.hold[nia_pkg::BIT_TOP_UNMASKABLE_LOCK] |
			   (q.central_irq_control[nia_pkg::BIT_TLI] & q.central_irq_control[nia_pkg::BIT_IEN]));
	end

	// Fixed chain: lower index wins at equal level; peripheral channel last
	always_comb begin
		win_ok  = 1'b0;
		win_idx = 4'h0;
		win_lvl = nia_pkg::LVL_NEVER;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (q.pend[i] && q.mask[i] && lvl[i] != nia_pkg::LVL_NEVER &&
			    (!win_ok || lvl[i] <= win_lvl)) begin
				win_ok  = 1'b1;
				win_idx = 4'(i);
				win_lvl = lvl[i];
			end
		end
		if (q.pctl[nia_pkg::BIT_PIP] && q.pctl[nia_pkg::BIT_PIM] &&
		    q.pctl[2:0] != nia_pkg::LVL_NEVER && (!win_ok || q.pctl[2:0] < win_lvl)) begin
			win_ok  = 1'b1;
			win_idx = 4'(NCH);
			win_lvl = q.pctl[2:0];
		end
		win_ok = win_ok & q.central_irq_control[nia_pkg::BIT_IEN] & (win_lvl < q.central_irq_control[2:0]);
	end

	// Lowest-index hold bit is the level to resume
	always_comb begin
		hl_idx   = 4'h7;
		next_lvl = nia_pkg::LVL_NEVER;
		for (int i = 6; i >= 0; i--) begin
			if (q.hold[i]) begin
				hl_idx   = 4'(i);
				next_lvl = 3'(i);
			end
		end
		entry_len = 5'(nia_pkg::ENTRY_BASE) +
			    (stack_in_rf_i ? 5'(nia_pkg::ENTRY_RF) : 5'h0) +
			    (q.central_irq_control[7] ? 5'(nia_pkg::ENTRY_SEG) : 5'h0) +
			    (wfi_i ? 5'(nia_pkg::ENTRY_WFI) : 5'h0);
	end

	always_comb begin
		n            = q;
		n.req.ack    = 1'b0;
		n.req.abort  = 1'b0;
		n.s_ext      = {q.s_ext[0], ext_pin_i};
		n.s_nmi      = {q.s_nmi[0], nmi_pin_i};
		n.last_ext   = src;
		n.last_nmi   = q.s_nmi[1];
		n.last_wdog  = wdog_eoc_i;
		n.arb_cnt    = (q.arb_cnt == nia_pkg::ARB_LAST) ? 3'h0 : q.arb_cnt + 3'h1;
		n.rdata      = 8'h00;

		// Register writes
		if (bus_i.wr) begin
			if (bus_i.addr == nia_pkg::ADDR_CENTRAL_IRQ_CONTROL) begin
				n.central_irq_control = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_EDGE) begin
				n.edge_sel = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_PEND) begin
				n.pend = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_MASK) begin
				n.mask = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_PRIO) begin
				n.prio = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_VECT) begin
				n.vect = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_HOLD) begin
				n.hold = {q.hold[7] | bus_i.wdata[7], bus_i.wdata[6:0]};
			end else if (bus_i.addr == nia_pkg::ADDR_PCTL) begin
				n.pctl = bus_i.wdata;
			end else if (bus_i.addr == nia_pkg::ADDR_PVEC) begin
				n.pvec = bus_i.wdata[6:0];
			end else if (bus_i.addr == nia_pkg::ADDR_SRCSEL) begin
				n.srcsel = bus_i.wdata;
			end
		end

		// Register reads
		if (bus_i.rd) begin
			if (bus_i.addr == nia_pkg::ADDR_CENTRAL_IRQ_CONTROL) begin
				n.rdata = q.central_irq_control;
			end else if (bus_i.addr == nia_pkg::ADDR_EDGE) begin
				n.rdata = q.edge_sel;
			end else if (bus_i.addr == nia_pkg::ADDR_PEND) begin
				n.rdata = q.pend;
			end else if (bus_i.addr == nia_pkg::ADDR_MASK) begin
				n.rdata = q.mask;
			end else if (bus_i.addr == nia_pkg::ADDR_PRIO) begin
				n.rdata = q.prio;
			end else if (bus_i.addr == nia_pkg::ADDR_VECT) begin
				n.rdata = q.vect;
			end else if (bus_i.addr == nia_pkg::ADDR_HOLD) begin
				n.rdata = q.hold;
			end else if (bus_i.addr == nia_pkg::ADDR_PCTL) begin
				n.rdata = q.pctl;
			end else if (bus_i.addr == nia_pkg::ADDR_STAT) begin
				n.rdata = {q.in_top, q.seg_saved, 3'h0, 3'(q.phase)};
			end else if (bus_i.addr == nia_pkg::ADDR_PVEC) begin
				n.rdata = {1'b0, q.pvec};
			end else if (bus_i.addr == nia_pkg::ADDR_SRCSEL) begin
				n.rdata = q.srcsel;
			end
		end

		// Hardware set wins over a same-cycle software clear
		n.pend = n.pend | ext_edge;
		if (top_edge) begin
			n.central_irq_control[nia_pkg::BIT_TOP_PENDING] = 1'b1;
		end
		if (periph_event_i) begin
			n.pctl[nia_pkg::BIT_PIP] = 1'b1;
		end

		case (q.phase)
			nia_pkg::ST_RUN: begin
				if (q.arb_cnt == nia_pkg::ARB_LAST && !q.in_top) begin
					if (top_req) begin
						n.central_irq_control[nia_pkg::BIT_TOP_PENDING] = top_edge;
						n.in_top     = 1'b1;
						n.req.ack    = 1'b1;
						n.req.top    = 1'b1;
						n.req.vector = q.vect;
						n.req.abort  = !insn_wrote_i;
						n.entry_cnt  = entry_len;
						n.phase      = nia_pkg::ST_ENTRY;
					end else if (win_ok) begin
						n.central_irq_control[nia_pkg::BIT_IEN] = 1'b0;
						if (win_idx < 4'(NCH)) begin
							n.pend[win_idx[2:0]] = ext_edge[win_idx[2:0]];
							n.req.vector = {q.vect[7:4], win_idx[2:0], 1'b0};
						end else begin
							n.pctl[nia_pkg::BIT_PIP] = periph_event_i;
							n.req.vector = {q.pvec, 1'b0};
						end
						if (q.central_irq_control[nia_pkg::BIT_IAM]) begin
							if (q.central_irq_control[2:0] != nia_pkg::LVL_NEVER) begin
								n.hold[q.central_irq_control[2:0]] = 1'b1;
							end
							n.central_irq_control[2:0] = win_lvl;
						end
						n.nest       = q.nest + 4'h1;
						n.seg_saved  = q.central_irq_control[7];
						n.req.ack    = 1'b1;
						n.req.top    = 1'b0;
						n.req.abort  = !insn_wrote_i;
						n.entry_cnt  = entry_len;
						n.phase      = nia_pkg::ST_ENTRY;
					end
				end
				if (iret_i) begin
					n.pop_step = {1'b1, q.central_irq_control[7], 2'b11};
					if (q.in_top) begin
						n.in_top = 1'b0;
					end else begin
						n.central_irq_control[nia_pkg::BIT_IEN] = 1'b1;
						if (q.central_irq_control[nia_pkg::BIT_IAM]) begin
							n.central_irq_control[2:0] = next_lvl;
							if (hl_idx != 4'h7) begin
								n.hold[hl_idx[2:0]] = 1'b0;
							end
						end
						n.nest = (q.nest == 4'h0) ? 4'h0 : q.nest - 4'h1;
					end
				end
			end
			nia_pkg::ST_ENTRY: begin
				n.entry_cnt = q.entry_cnt - 5'h1;
				if (q.entry_cnt == 5'h1) begin
					n.phase = nia_pkg::ST_RUN;
				end
			end
			default: begin
				n.phase = nia_pkg::ST_RUN;
			end
		endcase
		n.busy    = (n.phase == nia_pkg::ST_ENTRY);
		n.use_isr = (n.nest != 4'h0) && !n.seg_saved;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q           <= '0;
			q.central_irq_control      <= nia_pkg::CENTRAL_IRQ_CONTROL_RST;
			q.edge_sel  <= nia_pkg::EDGE_RST;
			q.prio      <= nia_pkg::PRIO_RST;
			q.vect      <= {4'h0, nia_pkg::VECT_LO_RST};
			q.hold      <= nia_pkg::HOLD_RST;
			q.pctl      <= nia_pkg::PCTL_RST;
			q.phase     <= nia_pkg::ST_RUN;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from state
	assign rdata_o      = q.rdata;
	assign req_o        = q.req;
	assign entry_busy_o = q.busy;
	assign use_isr_o    = q.use_isr;
	assign pop_step_o   = q.pop_step;
	assign cpl_o        = q.central_irq_control[2:0];

	property p_top_blocks;
		@(posedge clk_i) disable iff (!nrst_i)
		q.in_top |-> ##1 !(q.req.ack && !q.req.top);
	endproperty
	a_top_blocks: assert property (p_top_blocks) else $error("ack during top routine");

	property p_top_keeps;
		@(posedge clk_i) disable iff (!nrst_i)
		(q.phase == nia_pkg::ST_RUN && q.arb_cnt == nia_pkg::ARB_LAST && top_req && !q.in_top)
			|=> (q.central_irq_control[2:0] == $past(q.central_irq_control[2:0]) && q.hold[6:0] == $past(q.hold[6:0]));
	endproperty
	a_top_keeps: assert property (p_top_keeps) else $error("top entry altered level");

	property p_lock;
		@(posedge clk_i) disable iff (!nrst_i)
		q.hold[nia_pkg::BIT_TOP_UNMASKABLE_LOCK] |=> q.hold[nia_pkg::BIT_TOP_UNMASKABLE_LOCK];
	endproperty
	a_lock: assert property (p_lock) else $error("lock cleared");

	property p_ack_period;
		@(posedge clk_i) disable iff (!nrst_i)
		q.req.ack |-> q.arb_cnt == 3'h0;
	endproperty
	a_ack_period: assert property (p_ack_period) else $error("ack off sample point");

	property p_no_lvl7;
		@(posedge clk_i) disable iff (!nrst_i)
		win_ok |-> win_lvl != nia_pkg::LVL_NEVER;
	endproperty
	a_no_lvl7: assert property (p_no_lvl7) else $error("level seven chosen");

	property p_needs_ien;
		@(posedge clk_i) disable iff (!nrst_i)
		(!q.central_irq_control[nia_pkg::BIT_IEN] && !top_req) |=> !q.req.ack;
	endproperty
	a_needs_ien: assert property (p_needs_ien) else $error("ack with enable clear");

	property p_entry_len;
		@(posedge clk_i) disable iff (!nrst_i)
		$rose(entry_busy_o) |-> q.entry_cnt >= 5'(nia_pkg::ENTRY_BASE);
	endproperty
	a_entry_len: assert property (p_entry_len) else $error("entry too short");

	property p_edge_sets;
		@(posedge clk_i) disable iff (!nrst_i)
		(ext_edge != '0) |=> ((q.pend & $past(ext_edge)) == $past(ext_edge));
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge lost");
endmodule

// ===== rtl/nia_pkg.sv
// Package for the nested interrupt arbiter: register map, fields, timing
package nia_pkg;
	localparam logic [7:0] ADDR_CENTRAL_IRQ_CONTROL   = 8'h00_e6;
	localparam logic [7:0] ADDR_EDGE   = 8'h00_f2;
	localparam logic [7:0] ADDR_PEND   = 8'h00_f3;
	localparam logic [7:0] ADDR_MASK   = 8'h00_f4;
	localparam logic [7:0] ADDR_PRIO   = 8'h00_f5;
	localparam logic [7:0] ADDR_VECT   = 8'h00_f6;
	localparam logic [7:0] ADDR_HOLD   = 8'h00_f7;
	localparam logic [7:0] ADDR_PCTL   = 8'h00_f8;
	localparam logic [7:0] ADDR_STAT   = 8'h00_f9;
	localparam logic [7:0] ADDR_PVEC   = 8'h00_fa;
	localparam logic [7:0] ADDR_SRCSEL = 8'h00_fb;
	localparam logic [7:0] CENTRAL_IRQ_CONTROL_RST    = 8'h00_87;
	localparam logic [7:0] EDGE_RST    = 8'h00_00;
	localparam logic [7:0] PRIO_RST    = 8'h00_ff;
	localparam logic [3:0] VECT_LO_RST = 4'h6;
	localparam logic [7:0] HOLD_RST    = 8'h00_00;
	localparam logic [7:0] PCTL_RST    = 8'h00_70;
	localparam int         BIT_TOP_PENDING    = 6;
	localparam int         BIT_TLI     = 5;
	localparam int         BIT_IEN     = 4;
	localparam int         BIT_IAM     = 3;
	localparam int         BIT_TOP_EDGE_SELECT   = 3;
	localparam int         BIT_TOP_SOURCE_SELECT    = 2;
	localparam int         BIT_CHAN_A0_SOURCE_SELECT    = 1;
	localparam int         BIT_TOP_UNMASKABLE_LOCK    = 7;
	localparam int         BIT_PIP     = 7;
	localparam int         BIT_PIM     = 3;
	localparam logic [2:0] LVL_NEVER   = 3'h7;
	localparam int         CLK_MHZ     = 100;
	localparam int         ARB_NS      = 50;
	localparam int         ARB_CYC     = (ARB_NS * CLK_MHZ) / 1000;
	localparam logic [2:0] ARB_LAST    = 3'(ARB_CYC - 1);
	localparam int         ENTRY_BASE  = 18;
	localparam int         ENTRY_RF    = 2;
	localparam int         ENTRY_SEG   = 2;
	localparam int         ENTRY_WFI   = 1;

	typedef enum logic [2:0] {ST_RUN, ST_ENTRY, ST_SVC} nia_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} nia_bus_t;

	typedef struct packed {
		logic       ack;
		logic       top;
		logic [7:0] vector;
		logic       abort;
	} nia_req_t;
endpackage

// ===== dv/nia_core_model.sv
// Core sequencer model: returns from service a fixed time after entry
`timescale 1ns/1ps
module nia_core_model #(
	parameter int SVC = 6
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Arbiter side
	input  wire logic entry_busy_i,
	output logic      iret_o,
	output logic      insn_wrote_o,
	output logic      stack_in_rf_o,
	output logic      wfi_o
);
	int   cnt;
	logic busy_q;
	assign insn_wrote_o  = 1'b0;
	assign stack_in_rf_o = 1'b0;
	assign wfi_o         = 1'b0;
	// Return pulse some cycles after entry ends
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 0;
			busy_q <= 1'b0;
			iret_o <= 1'b0;
		end else begin
			busy_q <= entry_busy_i;
			iret_o <= (cnt == 1);
			if (busy_q && !entry_busy_i) begin
				cnt <= SVC;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// ===== dv/nested_interrupt_arbiter_test.sv
// Self-checking bench for the nested interrupt arbiter
`timescale 1ns/1ps
module nested_interrupt_arbiter_test;
	logic               clk_i;
	logic               nrst_i;
	nia_pkg::nia_bus_t  bus;
	nia_pkg::nia_req_t  req;
	logic [7:0]         rdata;
	logic [7:0]         pins;
	logic               iret, wrote, in_rf, wfi, busy, use_isr;
	logic [3:0]         pop_step;
	logic [2:0]         current_priority_level;
	logic [7:0]         exp_rd[$];
	logic [8:0]         exp_vec[$];
	logic [8:0]         ev;
	logic               nmi;
	logic               periph_evt;
	int                 exp_ent[$];
	int                 error_cnt, n_tests, ent_cnt, cyc;
	logic               rd_q;
	logic [7:0]         rnd;

	nia_arbiter u_nia_arbiter (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
		.ext_pin_i(pins), .periph_irq_i(8'h00), .nmi_pin_i(nmi), .wdog_eoc_i(1'b0),
		.wakeup_line_i(1'b0), .periph_event_i(periph_evt), .iret_i(iret), .insn_wrote_i(wrote),
		.stack_in_rf_i(in_rf), .wfi_i(wfi), .req_o(req), .entry_busy_o(busy),
		.use_isr_o(use_isr), .pop_step_o(pop_step), .cpl_o(current_priority_level));
	nia_core_model u_nia_core_model (.clk_i(clk_i), .nrst_i(nrst_i), .entry_busy_i(busy),
		.iret_o(iret), .insn_wrote_o(wrote), .stack_in_rf_o(in_rf), .wfi_o(wfi));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus.rd <= 1'b0;
	endtask

	// Result monitor: read data, acknowledges, entry length
	always @(posedge clk_i) begin
		if (rd_q) begin
			if (exp_rd.size() == 0) chk("read", 8'h00, 8'hxx);
			else chk("read", exp_rd.pop_front(), rdata);
		end
		rd_q <= bus.rd;
		if (req.ack === 1'b1) begin
			if (exp_vec.size() == 0) chk("ack", 8'h00, 8'hxx);
			else begin
				ev = exp_vec.pop_front();
				chk("vector", ev[7:0], req.vector);
				chk("top", {7'h00, ev[8]}, {7'h00, req.top});
			end
			chk("abort", 8'h01, {7'h00, req.abort});
		end
		if (busy === 1'b1) ent_cnt <= ent_cnt + 1;
		else if (ent_cnt != 0) begin
			chk("entry", 8'(exp_ent.pop_front()), 8'(ent_cnt));
			ent_cnt <= 0;
		end
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		bus = '0;
		pins = 8'h04;
		nmi = 1'b1;
		periph_evt = 1'b0;
		nrst_i = 1'b0;
		rd_q = 1'b0;
		ent_cnt = 0;
		cyc = 0;
		error_cnt = 0;
		n_tests = 0;
		rnd = 8'($urandom(18));
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		// Reset values and unmapped place
		rd(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, nia_pkg::CENTRAL_IRQ_CONTROL_RST);
		rd(nia_pkg::ADDR_EDGE, nia_pkg::EDGE_RST);
		rd(nia_pkg::ADDR_PEND, 8'h00);
		rd(nia_pkg::ADDR_MASK, 8'h00);
		rd(nia_pkg::ADDR_PRIO, nia_pkg::PRIO_RST);
		rd(nia_pkg::ADDR_HOLD, nia_pkg::HOLD_RST);
		rd(8'h00_10, 8'h00);
		$display("reset test done");
		// Random edge select readback, then rising ch3 falling ch2
		rnd = 8'($urandom());
		wr(nia_pkg::ADDR_EDGE, rnd);
		rd(nia_pkg::ADDR_EDGE, rnd);
		wr(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_0d);
		wr(nia_pkg::ADDR_SRCSEL, 8'h00_7f);
		wr(nia_pkg::ADDR_EDGE, 8'h00_08);
		repeat (4) @(posedge clk_i);
		pins <= 8'h08;
		repeat (6) @(posedge clk_i);
		rd(nia_pkg::ADDR_PEND, 8'h00_0c);
		$display("edge test done");
		// Lock bit cannot be cleared by software
		wr(nia_pkg::ADDR_HOLD, 8'h00_80);
		wr(nia_pkg::ADDR_HOLD, 8'h00_00);
		rd(nia_pkg::ADDR_HOLD, 8'h00_80);
		// Nested acknowledge of unmasked ch3 at level 1 from level 5
		wr(nia_pkg::ADDR_VECT, 8'h00_a6);
		wr(nia_pkg::ADDR_PRIO, 8'h00_00);
		wr(nia_pkg::ADDR_MASK, 8'h00_08);
		exp_vec.push_back({1'b0, 8'h00_a6});
		exp_ent.push_back(nia_pkg::ENTRY_BASE);
		wr(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_1d);
		repeat (12) @(posedge clk_i);
		chk("level", 8'h01, {5'h00, current_priority_level});
		chk("segment", 8'h01, {7'h00, use_isr});
		rd(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_09);
		rd(nia_pkg::ADDR_HOLD, 8'h00_a0);
		rd(nia_pkg::ADDR_PEND, 8'h00_04);
		repeat (40) @(posedge clk_i);
		rd(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_1d);
		rd(nia_pkg::ADDR_HOLD, 8'h00_80);
		chk("pop", 8'h0b, {4'h0, pop_step});
		chk("segment", 8'h00, {7'h00, use_isr});
		$display("nested test done");
		// Top level from the pin falling; peripheral request waits for its return
		exp_vec.push_back({1'b1, 8'h00_a6});
		exp_vec.push_back({1'b0, 8'h00_6a});
		exp_ent.push_back(nia_pkg::ENTRY_BASE);
		exp_ent.push_back(nia_pkg::ENTRY_BASE);
		nmi <= 1'b0;
		repeat (12) @(posedge clk_i);
		rd(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_1d);
		rd(nia_pkg::ADDR_HOLD, 8'h00_80);
		wr(nia_pkg::ADDR_PVEC, 8'h00_35);
		wr(nia_pkg::ADDR_PCTL, 8'h00_8a);
		rd(nia_pkg::ADDR_STAT, {5'h10, 3'(nia_pkg::ST_ENTRY)});
		repeat (70) @(posedge clk_i);
		rd(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_1d);
		rd(nia_pkg::ADDR_HOLD, 8'h00_80);
		rd(nia_pkg::ADDR_PCTL, 8'h00_0a);
		$display("top level test done");
		// Software pending at level 7 is never acknowledged
		wr(nia_pkg::ADDR_PRIO, 8'h00_ff);
		wr(nia_pkg::ADDR_PEND, 8'h00_0c);
		wr(nia_pkg::ADDR_PCTL, 8'h00_0f);
		wr(nia_pkg::ADDR_CENTRAL_IRQ_CONTROL, 8'h00_1f);
		periph_evt <= 1'b1;
		@(posedge clk_i);
		periph_evt <= 1'b0;
		repeat (30) @(posedge clk_i);
		rd(nia_pkg::ADDR_PEND, 8'h00_0c);
		rd(nia_pkg::ADDR_PCTL, 8'h00_8f);
		$display("level seven test done");
		repeat (3) @(posedge clk_i);
		tally_and_finish();
	end
endmodule
